//--- hdl/mmd_pkg.sv
// Purpose: constants for the memory map decoder of a small 4-bit controller
// Assumes: 14-bit program addresses, 10-bit data addresses, 4-bit digits
// Notes:   region bounds and vector/stack layout live here; checker, core model and bench repeat them as literals
package mmd_pkg;
    localparam int ROM_AW = 14;
    localparam int RAM_AW = 10;
    localparam int DIG_W  = 4;
    // rom regions
    localparam logic [13:0] ROM_VEC_LAST  = 14'h000f;
    localparam logic [13:0] ROM_ZP_LAST   = 14'h003f;
    localparam logic [13:0] ROM_PAT_LAST  = 14'h0fff;
    localparam logic [13:0] ROM_PAGE_LAST = 14'h0fff;  // per 4k step of rom size
    localparam logic [13:0] ROM_VEC_RESET = 14'h0000;
    localparam int          VEC_STRIDE    = 2;         // each vector slot, two words
    // ram regions
    localparam logic [9:0] RAM_INTC_LAST  = 10'h003;
    localparam logic [9:0] RAM_SFR1_LAST  = 10'h01f;
    localparam logic [9:0] RAM_FLAG_FIRST = 10'h020;
    localparam logic [9:0] RAM_FLAG_LAST  = 10'h023;
    localparam logic [9:0] RAM_SFR2_LAST  = 10'h03f;
    localparam logic [9:0] RAM_MR_FIRST   = 10'h040;
    localparam logic [9:0] RAM_MR_LAST    = 10'h04f;
    localparam logic [9:0] RAM_DATA_LAST  = 10'h1ff;
    localparam logic [9:0] RAM_STK_FIRST  = 10'h3c0;
    localparam logic [9:0] RAM_STK_LAST   = 10'h3ff;
    localparam int         STK_LEVELS     = 16;
    localparam int         RAM_DIGITS     = 512;
    // one-hot region select
    typedef enum logic [6:0] {
        MMD_RG_NONE = 7'h01,
        MMD_RG_INTC = 7'h02,
        MMD_RG_SFR  = 7'h04,
        MMD_RG_FLAG = 7'h08,
        MMD_RG_MR   = 7'h10,
        MMD_RG_DATA = 7'h20,
        MMD_RG_STK  = 7'h40
    } mmd_region_e;
    // stack engine states
    typedef enum logic [3:0] {
        MMD_ST_IDLE = 4'h1,
        MMD_ST_PUSH = 4'h2,
        MMD_ST_POP  = 4'h4,
        MMD_ST_DONE = 4'h8
    } mmd_state_e;
endpackage

//--- hdl/mmd_decode.sv
// Purpose: program and data memory map decoder with call/interrupt stack
// Assumes: the execution core issues one request a time on the same clock
// Notes:   the data array lives here; core handles instruction semantics
// Notes on behaviour
// [R1] reset or accepted interrupt fetches from its vector slot in 0000..000f
// [R2] short call targets are confined to rom 0000..003f
// [R3] pattern reads reach any rom address 0000..0fff
// [R4] program space spans 0000 up to 0fff/1fff/2fff/3fff per rom size
// [R5] data memory is 512 four-bit digits shared with mapped registers
// [R6] 000..003 hold interrupt bits, bit instructions only, per-bit limits
// [R7] 004..01f and 024..03f decode to special function registers
// [R8] core must not use bit instructions on special function registers
// [R9] 020..023 hold register flags, bit instructions only, per-bit limits
// [R10] 040..04f are sixteen memory registers for load/exchange
// [R11] call and interrupt push counter, status, carry: four digits, 16 levels
// [R12] plain return restores counter; interrupt return also status and carry
// [R13] unused stack digits behave as ordinary data memory; the code runs no bit instructions there, only whole-digit read/write
// [R14] each data address selects exactly one region
`timescale 1ns/100ps
`default_nettype none
module mmd_decode
    import mmd_pkg::*;
#(
    parameter int         ROM_PAGES  = 4,     // 1..4 blocks of 4k words
    parameter logic [3:0] BIT_SET_OK = 4'hf,  // per-bit set/clear/test permission masks
    parameter logic [3:0] BIT_CLR_OK = 4'hf,
    parameter logic [3:0] BIT_TST_OK = 4'hf
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // program fetch side
    input  wire logic                     vec_req,       // reset/interrupt accepted
    input  wire logic [2:0]               vec_num,       // 0 = reset
    input  wire logic                     pfetch_req,
    input  wire logic [mmd_pkg::ROM_AW-1:0] pfetch_addr,
    input  wire logic                     short_call_req,
    input  wire logic [5:0]               short_call_tgt,
    input  wire logic                     pattern_req,
    input  wire logic [mmd_pkg::ROM_AW-1:0] pattern_addr,
    output logic [mmd_pkg::ROM_AW-1:0]    rom_addr,
    output logic                          rom_strobe,
    output logic                          rom_fault,
    // data access side
    input  wire logic                     dreq,
    input  wire logic                     dwrite,
    input  wire logic                     bit_set_instr,
    input  wire logic                     bit_clear_instr,
    input  wire logic                     bit_test_instr,
    input  wire logic [1:0]               bit_sel,
    input  wire logic                     memreg_instr,  // load_from_memreg / exchange_memreg
    input  wire logic [mmd_pkg::RAM_AW-1:0] daddr,
    input  wire logic [mmd_pkg::DIG_W-1:0]  dwdata,
    output logic [mmd_pkg::DIG_W-1:0]     drdata,
    output logic                          dvalid,
    output logic                          daccess_err,
    output logic [6:0]                    dregion,
    // stack side
    input  wire logic                     call_push,
    input  wire logic [mmd_pkg::ROM_AW-1:0] push_pc,
    input  wire logic                     push_status,
    input  wire logic                     push_carry,
    input  wire logic                     subroutine_return_instr,
    input  wire logic                     interrupt_return_instr,
    output logic [mmd_pkg::ROM_AW-1:0]    program_counter,
    output logic                          status_flag,
    output logic                          carry_flag,
    output logic                          restore_valid,
    output logic                          flags_restored,
    output logic                          stack_busy,
    output logic                          stack_ovf
);
    import mmd_pkg::*;

    // single region per address; priority chain cannot overlap
    function automatic mmd_region_e region_of(input logic [RAM_AW-1:0] a);
        if (a <= RAM_INTC_LAST)                        return MMD_RG_INTC;
        else if (a <= RAM_SFR1_LAST)                   return MMD_RG_SFR;
        else if (a <= RAM_FLAG_LAST)                   return MMD_RG_FLAG;
        else if (a <= RAM_SFR2_LAST)                   return MMD_RG_SFR;
        else if (a <= RAM_MR_LAST)                     return MMD_RG_MR;
        else if (a <= RAM_DATA_LAST)                   return MMD_RG_DATA;
        else if (a >= RAM_STK_FIRST)                   return MMD_RG_STK;
        else                                           return MMD_RG_NONE;
    endfunction

    // 512 data digits (000..1ff) plus 64 stack digits; stack shares the port
    logic [DIG_W-1:0] mem [0:RAM_DIGITS-1];
    logic [DIG_W-1:0] stk [0:(STK_LEVELS*4)-1];

    mmd_region_e      reg_now;
    logic             bit_op;
    logic             bit_ok;
    logic [13:0]      rom_top;
    logic [5:0]       wptr;
    logic [5:0]       rptr;
    logic [3:0]       stk_lvl_q;
    logic [3:0]       stk_lvl_d;
    logic             full_q;

    assign reg_now = region_of(daddr);                                         // [R14]
    assign bit_op  = bit_set_instr | bit_clear_instr | bit_test_instr;
    assign bit_ok  = (bit_set_instr & BIT_SET_OK[bit_sel]) | (bit_clear_instr & BIT_CLR_OK[bit_sel])
                   | (bit_test_instr & BIT_TST_OK[bit_sel]);
    assign rom_top = ROM_PAGE_LAST + 14'((ROM_PAGES - 1) * 4096);              // [R4]
    assign wptr    = {stk_lvl_q, 2'b00};

    // program address mux; vector first since it preempts normal fetch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rom_addr   <= ROM_VEC_RESET;                                       // [R1]
            rom_strobe <= 1'b0;
            rom_fault  <= 1'b0;
        end else begin
            rom_strobe <= vec_req | short_call_req | pattern_req | pfetch_req;
            rom_fault  <= 1'b0;
            if (vec_req) begin
                rom_addr <= 14'(vec_num * VEC_STRIDE) & ROM_VEC_LAST;          // [R1]
            end else if (short_call_req) begin
                rom_addr <= {8'h00, short_call_tgt} & ROM_ZP_LAST;             // [R2]
            end else if (pattern_req) begin
                rom_addr  <= pattern_addr & ROM_PAT_LAST;                      // [R3]
                rom_fault <= pattern_addr > ROM_PAT_LAST;
            end else if (pfetch_req) begin
                rom_addr  <= pfetch_addr;                                      // [R4]
                rom_fault <= pfetch_addr > rom_top;
            end
        end
    end

    // data access: flag areas bit-only, sfr whole-digit only, mr via memreg ops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drdata      <= 4'h0;
            dvalid      <= 1'b0;
            daccess_err <= 1'b0;
            dregion     <= MMD_RG_NONE;
        end else begin
            dvalid      <= dreq;
            dregion     <= dreq ? reg_now : MMD_RG_NONE;
            daccess_err <= 1'b0;
            drdata      <= 4'h0;
            if (dreq) begin
                case (reg_now)
                    MMD_RG_INTC, MMD_RG_FLAG: begin                            // [R6] [R9]
                        if (!bit_op || !bit_ok) begin
                            daccess_err <= 1'b1;
                        end else if (bit_test_instr) begin
                            drdata <= {3'b000, mem[daddr[8:0]][bit_sel]};
                        end else begin
                            mem[daddr[8:0]][bit_sel] <= bit_set_instr;
                        end
                    end
                    MMD_RG_SFR: begin                                          // [R7]
                        // bit ops here are a core fault; flagged, not executed
                        if (bit_op) begin
                            daccess_err <= 1'b1;                               // [R8]
                        end else if (dwrite) begin
                            mem[daddr[8:0]] <= dwdata;
                        end else begin
                            drdata <= mem[daddr[8:0]];
                        end
                    end
                    MMD_RG_MR, MMD_RG_DATA: begin                              // [R5] [R10]
                        // memory registers answer only the memreg load/exchange; refused ops leave them alone
                        if (reg_now == MMD_RG_MR && (bit_op || !memreg_instr)) begin
                            daccess_err <= 1'b1;                               // [R10]
                        end else if (bit_op) begin
                            if (bit_test_instr) drdata <= {3'b000, mem[daddr[8:0]][bit_sel]};
                            else mem[daddr[8:0]][bit_sel] <= bit_set_instr;
                        end else if (dwrite) begin
                            mem[daddr[8:0]] <= dwdata;
                        end else begin
                            drdata <= mem[daddr[8:0]];
                        end
                    end
                    MMD_RG_STK: begin                                          // [R13]
                        if (dwrite) stk[daddr[5:0]] <= dwdata;
                        else drdata <= stk[daddr[5:0]];
                    end
                    default: daccess_err <= 1'b1;
                endcase
            end
            // stack push wins the stack array this cycle; core never overlaps
            if (call_push && !full_q) begin                                    // [R11]
                stk[wptr]        <= push_pc[3:0];
                stk[wptr + 6'd1] <= push_pc[7:4];
                stk[wptr + 6'd2] <= push_pc[11:8];
                stk[wptr + 6'd3] <= {push_status, push_carry, push_pc[13:12]};
            end
        end
    end

    // once full the counter parks at 15, so the top entry sits at the level itself
    assign rptr      = full_q ? {stk_lvl_q, 2'b00} : {stk_lvl_q - 4'd1, 2'b00};
    assign stk_lvl_d = stk_lvl_q;

    // level counter and restore path
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stk_lvl_q       <= 4'h0;
            full_q          <= 1'b0;
            program_counter <= 14'h0000;
            status_flag     <= 1'b0;
            carry_flag      <= 1'b0;
            restore_valid   <= 1'b0;
            flags_restored  <= 1'b0;
            stack_busy      <= 1'b0;
            stack_ovf       <= 1'b0;
        end else begin
            restore_valid  <= 1'b0;
            flags_restored <= 1'b0;
            stack_busy     <= call_push | subroutine_return_instr | interrupt_return_instr;
            if (call_push) begin
                if (full_q) begin
                    stack_ovf <= 1'b1;                                         // sticky until reset
                end else if (stk_lvl_q == 4'hf) begin
                    full_q <= 1'b1;
                end else begin
                    stk_lvl_q <= stk_lvl_d + 4'd1;                             // [R11]
                end
            end else if ((subroutine_return_instr || interrupt_return_instr) && (full_q || stk_lvl_q != 4'h0)) begin
                program_counter <= {stk[rptr + 6'd3][1:0], stk[rptr + 6'd2], stk[rptr + 6'd1], stk[rptr]};
                restore_valid   <= 1'b1;                                       // [R12]
                if (interrupt_return_instr) begin
                    status_flag    <= stk[rptr + 6'd3][3];                     // [R12]
                    carry_flag     <= stk[rptr + 6'd3][2];
                    flags_restored <= 1'b1;
                end
                if (full_q) full_q <= 1'b0;
                else stk_lvl_q <= stk_lvl_q - 4'd1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/mmd_core_model.sv
// Purpose: stand-in for the execution core that issues data requests
// Assumes: one registered request per go pulse from the bench
// Notes:   idle address and data lines flip so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module mmd_core_model (
    // command from the bench
    input  wire logic       clk, sys_rst, go, wr, abuse,
    input  wire logic [1:0] bop,
    input  wire logic [9:0] adr,
    input  wire logic [3:0] wd,
    // data pins of the decoder
    output logic            dreq, dwrite, bit_set_instr, bit_clear_instr, bit_test_instr,
    output logic [9:0]      daddr,
    output logic [3:0]      dwdata
);
    logic g;
    // a sane core never aims bit ops at the special window; abuse lets one through
    assign g = go && (abuse || bop == 2'h0 || !(adr inside {[10'h004:10'h01f], [10'h024:10'h03f]}));
    // request pins, registered like the real core
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {dreq, dwrite, bit_set_instr, bit_clear_instr, bit_test_instr} <= 5'h00;
            daddr <= 10'h000;
            dwdata <= 4'h0;
        end else begin
            {dreq, dwrite} <= {g, g && wr};
            {bit_set_instr, bit_clear_instr, bit_test_instr} <= {g && bop == 2'h1, g && bop == 2'h2, g && bop == 2'h3};
            daddr <= g ? adr : ~daddr;
            dwdata <= g ? wd : ~dwdata;
        end
    end
endmodule
`default_nettype wire

//--- verification/mmd_decode_asserts.sv
// Purpose: port-level checks of the memory map decoder
// Assumes: bit permission masks left all-allowed
// Notes:   ports grouped on few lines to keep the checker small
`timescale 1ns/100ps
`default_nettype none
module mmd_decode_asserts #(
    parameter int ROM_PAGES = 4
) (
    input wire logic        clk, sys_rst, vec_req, short_call_req, pattern_req, pfetch_req, rom_strobe, rom_fault,
    input wire logic        dreq, bit_set_instr, bit_clear_instr, bit_test_instr, daccess_err, call_push,
    input wire logic        subroutine_return_instr, interrupt_return_instr, restore_valid, flags_restored, stack_busy,
    input wire logic [2:0]  vec_num,
    input wire logic [5:0]  short_call_tgt,
    input wire logic [13:0] pattern_addr, pfetch_addr, rom_addr,
    input wire logic [9:0]  daddr,
    input wire logic [6:0]  dregion
);
    localparam logic [13:0] TOP = 14'(ROM_PAGES * 4096 - 1);
    wire logic bop;
    // any single-bit instruction
    assign bop = bit_set_instr | bit_clear_instr | bit_test_instr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_vec_slot: assert property (vec_req |=> rom_strobe && rom_addr == {10'h000, $past(vec_num), 1'b0})
        else $error("vector fetch address wrong");
    a_short_tgt: assert property (short_call_req && !vec_req |=> rom_addr == {8'h00, $past(short_call_tgt)})
        else $error("short call left zero page");
    a_pat_range: assert property (pattern_req && !vec_req && !short_call_req |=> rom_fault == ($past(pattern_addr) > 14'h0fff))
        else $error("pattern range fault wrong");
    a_prog_top: assert property (pfetch_req && !vec_req && !short_call_req && !pattern_req |=> rom_fault == ($past(pfetch_addr) > TOP))
        else $error("program top fault wrong");
    a_region_one: assert property ($onehot(dregion))
        else $error("region select not one-hot");
    a_gap_err: assert property (dreq && daddr inside {[10'h200:10'h3bf]} |=> daccess_err)
        else $error("unmapped data access accepted");
    a_intc_bit: assert property (dreq && !bop && daddr <= 10'h003 |=> daccess_err)
        else $error("plain access to interrupt bits accepted");
    a_sfr_nobit: assert property (dreq && bop && daddr inside {[10'h004:10'h01f], [10'h024:10'h03f]} |=> daccess_err)
        else $error("bit op on special register accepted");
    a_flag_bit: assert property (dreq && bop && daddr inside {[10'h020:10'h023]} |=> !daccess_err && dregion == 7'h08)
        else $error("bit op on flag area mishandled");
    a_mr_region: assert property (dreq && !bop && daddr inside {[10'h040:10'h04f]} |=> dregion == 7'h10)
        else $error("memory register region wrong");
    a_push_busy: assert property (call_push |=> stack_busy)
        else $error("push not started");
    a_iret_flags: assert property (interrupt_return_instr && !call_push |=> restore_valid && flags_restored)
        else $error("interrupt return left flags");
    a_ret_pconly: assert property (subroutine_return_instr && !interrupt_return_instr && !call_push
        |=> restore_valid && !flags_restored) else $error("plain return restored flags");
endmodule
bind mmd_decode mmd_decode_asserts #(.ROM_PAGES(ROM_PAGES)) u_chk (.clk, .sys_rst, .vec_req, .short_call_req,
    .pattern_req, .pfetch_req, .rom_strobe, .rom_fault, .dreq, .bit_set_instr, .bit_clear_instr, .bit_test_instr,
    .daccess_err, .call_push, .subroutine_return_instr, .interrupt_return_instr, .restore_valid, .flags_restored,
    .stack_busy, .vec_num, .short_call_tgt, .pattern_addr, .pfetch_addr, .rom_addr, .daddr, .dregion);
`default_nettype wire

//--- verification/mmd_decode_tb.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: two rom pages so the program top sits at 1fff
// Notes:   data and stack contents mirrored in an int array and a queue
`timescale 1ns/100ps
`default_nettype none
module mmd_decode_tb;
    import mmd_pkg::*;
    logic clk = 0, sys_rst, vec_req = 0, short_call_req = 0, pattern_req = 0, pfetch_req = 0, call_push = 0;
    logic subroutine_return_instr = 0, interrupt_return_instr = 0, go = 0, wr = 0, abuse = 0, memreg_instr = 0;
    logic push_status = 0, push_carry = 0, rom_strobe, rom_fault, dreq, dwrite, bit_set_instr, bit_clear_instr;
    logic bit_test_instr, dvalid, daccess_err, status_flag, carry_flag, restore_valid, flags_restored;
    logic stack_busy, stack_ovf;
    logic [2:0] vec_num = 0;
    logic [5:0] short_call_tgt = 0;
    logic [1:0] bop = 0, bit_sel = 0;
    logic [13:0] pattern_addr = 0, pfetch_addr = 0, push_pc = 0, rom_addr, program_counter;
    logic [9:0] adr = 0, daddr;
    logic [3:0] wd = 0, dwdata, drdata;
    logic [6:0] dregion;
    int err_total = 0, samples_checked = 0, seed = 32'hda19, mem[1024], known[1024], stk[$], v, i, j, e;
    // free-running 125 MHz clock
    always #4 clk = ~clk;
    mmd_decode #(.ROM_PAGES(2)) u_dut (.clk, .sys_rst, .vec_req, .vec_num, .pfetch_req, .pfetch_addr,
        .short_call_req, .short_call_tgt, .pattern_req, .pattern_addr, .rom_addr, .rom_strobe, .rom_fault, .dreq,
        .dwrite, .bit_set_instr, .bit_clear_instr, .bit_test_instr, .bit_sel, .memreg_instr, .daddr, .dwdata,
        .drdata, .dvalid, .daccess_err, .dregion, .call_push, .push_pc, .push_status, .push_carry,
        .subroutine_return_instr, .interrupt_return_instr, .program_counter, .status_flag, .carry_flag,
        .restore_valid, .flags_restored, .stack_busy, .stack_ovf);
    mmd_core_model u_core (.clk, .sys_rst, .go, .wr, .abuse, .bop, .adr, .wd, .dreq, .dwrite, .bit_set_instr,
        .bit_clear_instr, .bit_test_instr, .daddr, .dwdata);
    task automatic chk(input logic [23:0] g, input logic [23:0] x);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("unexpected at %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic close_out;
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one rom request: 0 vector, 1 short call, 2 pattern, 3 fetch
    task automatic rom(input int k, input logic [13:0] a, input logic [13:0] x, input logic f);
        @(posedge clk);
        {vec_num, short_call_tgt, pattern_addr, pfetch_addr} <= {a[2:0], a[5:0], a, a};
        {vec_req, short_call_req, pattern_req, pfetch_req} <= {k == 0, k == 1, k == 2, k == 3};
        @(posedge clk);
        {vec_req, short_call_req, pattern_req, pfetch_req} <= 4'h0;
        #1;
        if (f && k == 3) chk({rom_strobe, rom_fault}, 2'h3);
        else chk({rom_strobe, rom_fault, rom_addr}, {1'b1, f, x});
    endtask
    // one data access through the core model, answer awaited under a bound
    task automatic dacc(input logic w, input logic [1:0] b, input logic [9:0] a, input logic [3:0] d,
                        input logic [6:0] rg, input logic er);
        int n;
        logic [1:0] s;
        @(posedge clk);
        {go, wr, bop, adr, wd, abuse, memreg_instr} <= {1'b1, w, b, a, d, er && b != 2'h0, rg == 7'h10};
        s = 2'($random(seed));
        bit_sel <= s;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (n = 0; n < 6 && dvalid !== 1'b1 && daccess_err !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 6) begin
            err_total++;
            close_out();
        end
        chk(daccess_err, er);
        if (!er) chk(dregion, rg);
        if (!er && !w && b == 2'h0 && rg inside {7'h10, 7'h20, 7'h40}) chk(drdata, mem[a][3:0]);
        if (!er && b == 2'h3 && known[a][s]) chk(drdata, {3'b000, mem[a][s]});
        if (!er && b inside {2'h1, 2'h2}) {known[a][s], mem[a][s]} = {1'b1, b == 2'h1};
        if (w && !er) mem[a] = d;
    endtask
    // stack operation: 0 push, 1 plain return, 2 interrupt return
    task automatic stk_op(input int k);
        @(posedge clk);
        {push_pc, push_status, push_carry} <= 16'($random(seed));
        {call_push, subroutine_return_instr, interrupt_return_instr} <= {k == 0, k == 1, k == 2};
        @(posedge clk);
        e = k == 0 ? {push_carry, push_status, push_pc} : stk.pop_back();
        {call_push, subroutine_return_instr, interrupt_return_instr} <= 3'h0;
        #1;
        if (k == 0) stk.push_back(e);
        if (k == 0) chk(stack_busy, 1'b1);
        else chk({restore_valid, flags_restored, program_counter}, {1'b1, k == 2, e[13:0]});
        if (k == 2) chk({status_flag, carry_flag}, {e[14], e[15]});
    endtask
    initial begin
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({dregion, rom_addr}, {7'h01, 14'h0000});
        for (i = 0; i < 8; i++) rom(0, 14'(i), 14'(2 * i), 1'b0);
        repeat (6) begin
            v = $random(seed);
            rom(1, v[13:0], v[5:0], 1'b0);
            rom(2, v[13:0], v[11:0], v[13:12] != 2'h0);
            rom(3, v[13:0], v[13:0], v[13:0] > 14'h1fff);
        end
        rom(2, 14'h0fff, 14'h0fff, 1'b0);
        rom(3, 14'h1fff, 14'h1fff, 1'b0);
        rom(3, 14'h2000, 14'h2000, 1'b1);
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            j = 80 + (v & 32'h1ff) % 432;
            dacc(1'b1, 2'h0, 10'(j), v[11:8], 7'h20, 1'b0);
            dacc(1'b0, 2'h0, 10'(j), 4'h0, 7'h20, 1'b0);
        end
        dacc(1'b1, 2'h0, 10'h04f, 4'h9, 7'h10, 1'b0);
        dacc(1'b0, 2'h0, 10'h04f, 4'h0, 7'h10, 1'b0);
        dacc(1'b0, 2'h0, 10'h040, 4'h0, 7'h00, 1'b1);
        dacc(1'b0, 2'h0, 10'h200, 4'h0, 7'h00, 1'b1);
        dacc(1'b1, 2'h0, 10'h3bf, 4'h1, 7'h00, 1'b1);
        dacc(1'b0, 2'h0, 10'h003, 4'h0, 7'h00, 1'b1);
        dacc(1'b1, 2'h0, 10'h020, 4'h1, 7'h00, 1'b1);
        for (i = 3; i < 24; i++) dacc(1'b0, 2'(1 + i % 3), 10'h000, 4'h0, 7'h02, 1'b0);
        for (i = 3; i < 24; i++) dacc(1'b0, 2'(1 + i % 3), 10'h023, 4'h0, 7'h08, 1'b0);
        dacc(1'b0, 2'h0, 10'h004, 4'h0, 7'h04, 1'b0);
        dacc(1'b0, 2'h3, 10'h03f, 4'h0, 7'h00, 1'b1);
        for (i = 0; i < 3; i++) stk_op(0);
        foreach (stk[k]) for (j = 0; j < 4; j++) begin
            v = stk[k] >> (4 * j);
            mem[960 + 4 * k + j] = j == 3 ? {v[2], v[3], v[1:0]} : v[3:0];
            dacc(1'b0, 2'h0, 10'(960 + 4 * k + j), 4'h0, 7'h40, 1'b0);
        end
        dacc(1'b1, 2'h0, 10'h3fc, 4'ha, 7'h40, 1'b0);
        dacc(1'b0, 2'h0, 10'h3fc, 4'h0, 7'h40, 1'b0);
        stk_op(2);
        stk_op(1);
        stk_op(2);
        for (i = 0; i < 16; i++) stk_op(0);
        chk(stack_ovf, 1'b0);
        stk_op(0);
        chk(stack_ovf, 1'b1);
        void'(stk.pop_back());
        stk_op(2);
        close_out();
    end
endmodule
`default_nettype wire
